// file: smon_pkg.sv
`default_nettype none
package smon_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_TICK_NS = 1000000;
	localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
	localparam int NUM_CH = 3;
	localparam logic [3:0] FIFTH_SCREEN_LAYOUT = 4'h5;
	// Linearisation: 11 points, 512 mV apart, 0..5120 mV
	localparam int LIN_POINTS = 11;
	localparam int LIN_SEG_SHIFT = 9;
	localparam logic [15:0] LIN_FULL_MV = 16'h1400;
	// Register map
	localparam logic [1:0] REGION_GLOBAL = 2'h0;
	localparam logic [1:0] REGION_CH = 2'h1;
	localparam logic [1:0] REGION_SLOT = 2'h2;
	localparam logic [5:0] OFS_RPM_LIMIT = 6'h00;
	localparam logic [5:0] OFS_HOLD_MS = 6'h04;
	localparam logic [5:0] OFS_HOLDOFF_MS = 6'h08;
	localparam logic [5:0] OFS_STATUS = 6'h0C;
	localparam logic [5:0] OFS_INT_STAT = 6'h10;
	localparam logic [5:0] OFS_INT_MASK = 6'h14;
	localparam logic [7:0] ADDR_LIN_WR = 8'h70;
	localparam logic [3:0] OFS_CFG = 4'h0;
	localparam logic [3:0] OFS_LIM_A = 4'h4;
	localparam logic [3:0] OFS_LIM_B = 4'h8;
	localparam logic [3:0] OFS_AUX = 4'hC;
	// Field positions
	localparam int CFG_THERM_BIT = 0;
	localparam int CFG_FILT_LSB = 1;
	localparam int ITEM_MAX_EN_BIT = 2;
	localparam int ITEM_MIN_EN_BIT = 3;
	localparam int LIN_PT_LSB = 16;
	localparam int LIN_CH_LSB = 20;
	localparam int IRQ_ALARM_LSB = 0;
	localparam int IRQ_ERR_LSB = 3;
	localparam logic [1:0] SRC_NONE = 2'h3;
	// Reset values
	localparam logic [15:0] RPM_LIMIT_RST = 16'h0000;
	localparam logic [15:0] HOLD_MS_RST = 16'h03E8;
	localparam logic [15:0] HOLDOFF_MS_RST = 16'h1388;
	localparam logic [15:0] ERR_HI_RST = 16'hFFFF;
	localparam logic [15:0] ERR_LO_RST = 16'h0000;
	localparam logic [15:0] DEFAULT_RST = 16'h0000;
	localparam logic [15:0] LIM_MAX_RST = 16'hFFFF;
	localparam logic [15:0] LIM_MIN_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [1:0] {
		PG_IDLE = 2'b00,
		PG_HOLD = 2'b01,
		PG_HOLDOFF = 2'b11
	} smon_page_e;
endpackage
`default_nettype wire

// file: smon_top.sv
// Summary of operation
// - Alarm when item above max or below min
// - No alarms while engine speed below limit
// - Both limits set: alarm outside window
// - Warning page held for hold duration
// - Hold-off timer blocks page after hold
// - Item on layout: page once, then red
// - Fifth layout never shows alarm warning
// - Any alarm: active flag; red only for alarmed items on layout
// - Three 0-5V inputs routed to items
// - Input above high error limit is error
// - Input below low error limit is error
// - Error input drives default reading instead
// - Recursive filter, larger constant smooths more
// - Linearisation table converts volts to units
// - Thermistor type enables input pull-up
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module smon_top
	import smon_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_sample_valid,
	input wire logic [1:0] i_sample_chan,
	input wire logic [15:0] i_sample_mv,
	input wire logic [15:0] i_engine_rpm,
	input wire logic [3:0] i_layout,
	input wire logic [2:0] i_item_on_layout,
	output logic [2:0] o_pullup_en,
	output logic o_warning_page,
	output logic [2:0] o_item_red,
	output logic o_alarm_active,
	output logic o_irq
);
	localparam int TW = $clog2(TICK_CYCLES);

	if (TICK_CYCLES < 2) begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	function automatic logic addr_ok(input logic [7:0] a);
		logic [1:0] rg;
		rg = a[7:6];
		addr_ok = (a[1:0] == 2'h0) &&
			((rg == REGION_GLOBAL && a[5:0] <= OFS_INT_MASK) ||
			a == ADDR_LIN_WR ||
			((rg == REGION_CH || rg == REGION_SLOT) && a[5:4] != 2'h3));
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic [15:0] filter_step(input logic [15:0] y,
		input logic [15:0] x, input logic [3:0] k);
		logic signed [16:0] d;
		d = $signed({1'b0, x}) - $signed({1'b0, y});
		filter_step = y + 16'(d >>> k);
	endfunction

	function automatic logic [15:0] linearise(input logic [15:0] v,
		input logic [15:0] tab [LIN_POINTS]);
		logic [3:0] i;
		logic signed [17:0] dy;
		logic signed [27:0] p;
		i = v[12:9];
		dy = 18'($signed({1'b0, tab[4'(i + 4'h1)]})) -
			18'($signed({1'b0, tab[i]}));
		p = 28'(dy * $signed({1'b0, v[8:0]}));
		if (v >= LIN_FULL_MV)
			linearise = tab[LIN_POINTS - 1];
		else
			linearise = tab[i] + 16'(p >>> LIN_SEG_SHIFT);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [15:0] rpm_limit, hold_ms, holdoff_ms;
	logic [5:0] int_stat, int_mask;
	logic [3:0] filt_shift [NUM_CH];
	logic [15:0] err_hi [NUM_CH];
	logic [15:0] err_lo [NUM_CH];
	logic [15:0] dflt [NUM_CH];
	logic [15:0] lin [NUM_CH][LIN_POINTS];
	logic [1:0] src [NUM_CH];
	logic [2:0] max_en, min_en, therm;
	logic [15:0] lim_max [NUM_CH];
	logic [15:0] lim_min [NUM_CH];
	logic [15:0] filt [NUM_CH];
	logic [15:0] chan_val [NUM_CH];
	logic [15:0] item_val [NUM_CH];
	logic [2:0] in_err, err_q, alarm, alarm_q, shown_once;
	logic [7:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic do_wr;
	logic [1:0] wsel;
	logic [31:0] rd_word;
	logic [1:0] rsel;
	logic [TW-1:0] tick_cnt;
	logic ms_tick;
	logic [15:0] ms_left;
	smon_page_e page_state;
	logic [2:0] trig;
	logic page_req;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channels; address and data taken in either order
	assign do_wr = !o_awready && !o_wready && !o_bvalid;
	assign wsel = aw_q[5:4];

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
			aw_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				o_awready <= 1'b0;
				aw_q <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				o_wready <= 1'b0;
				wd_q <= i_wdata;
				ws_q <= i_wstrb;
			end
			if (do_wr) begin
				o_bvalid <= 1'b1;
				o_bresp <= addr_ok(aw_q) ? RESP_OKAY : RESP_DECERR;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rpm_limit <= RPM_LIMIT_RST;
			hold_ms <= HOLD_MS_RST;
			holdoff_ms <= HOLDOFF_MS_RST;
			int_mask <= 6'h00;
			therm <= 3'h0;
			max_en <= 3'h0;
			min_en <= 3'h0;
			for (int c = 0; c < NUM_CH; c++) begin
				filt_shift[c] <= 4'h0;
				err_hi[c] <= ERR_HI_RST;
				err_lo[c] <= ERR_LO_RST;
				dflt[c] <= DEFAULT_RST;
				src[c] <= SRC_NONE;
				lim_max[c] <= LIM_MAX_RST;
				lim_min[c] <= LIM_MIN_RST;
				for (int p = 0; p < LIN_POINTS; p++)
					lin[c][p] <= 16'(p << LIN_SEG_SHIFT);
			end
		end else if (do_wr && addr_ok(aw_q)) begin
			if (aw_q == ADDR_LIN_WR) begin
				if (wd_q[LIN_CH_LSB +: 2] != SRC_NONE &&
					wd_q[LIN_PT_LSB +: 4] < 4'(LIN_POINTS))
					lin[wd_q[LIN_CH_LSB +: 2]][wd_q[LIN_PT_LSB +: 4]] <=
						merge16(16'h0, wd_q, ws_q);
			end else if (aw_q[7:6] == REGION_GLOBAL) begin
				case (aw_q[5:0])
					OFS_RPM_LIMIT: rpm_limit <= merge16(rpm_limit, wd_q, ws_q);
					OFS_HOLD_MS: hold_ms <= merge16(hold_ms, wd_q, ws_q);
					OFS_HOLDOFF_MS:
						holdoff_ms <= merge16(holdoff_ms, wd_q, ws_q);
					OFS_INT_MASK: if (ws_q[0]) int_mask <= wd_q[5:0];
					default: ;
				endcase
			end else if (aw_q[7:6] == REGION_CH) begin
				case (aw_q[3:0])
					OFS_CFG: if (ws_q[0]) begin
						therm[wsel] <= wd_q[CFG_THERM_BIT];
						filt_shift[wsel] <= wd_q[CFG_FILT_LSB +: 4];
					end
					OFS_LIM_A: err_hi[wsel] <= merge16(err_hi[wsel], wd_q, ws_q);
					OFS_LIM_B: err_lo[wsel] <= merge16(err_lo[wsel], wd_q, ws_q);
					default: dflt[wsel] <= merge16(dflt[wsel], wd_q, ws_q);
				endcase
			end else begin
				case (aw_q[3:0])
					OFS_CFG: if (ws_q[0]) begin
						src[wsel] <= wd_q[1:0];
						max_en[wsel] <= wd_q[ITEM_MAX_EN_BIT];
						min_en[wsel] <= wd_q[ITEM_MIN_EN_BIT];
					end
					OFS_LIM_A:
						lim_max[wsel] <= merge16(lim_max[wsel], wd_q, ws_q);
					OFS_LIM_B:
						lim_min[wsel] <= merge16(lim_min[wsel], wd_q, ws_q);
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channels; data one cycle after address taken
	assign rsel = i_araddr[5:4];

	always_comb begin
		rd_word = 32'h0;
		if (i_araddr[7:6] == REGION_GLOBAL) begin
			case (i_araddr[5:0])
				OFS_RPM_LIMIT: rd_word = {16'h0, rpm_limit};
				OFS_HOLD_MS: rd_word = {16'h0, hold_ms};
				OFS_HOLDOFF_MS: rd_word = {16'h0, holdoff_ms};
				OFS_STATUS: rd_word = {24'h0, page_state == PG_HOLD,
					o_alarm_active, alarm, in_err};
				OFS_INT_STAT: rd_word = {26'h0, int_stat};
				OFS_INT_MASK: rd_word = {26'h0, int_mask};
				default: rd_word = 32'h0;
			endcase
		end else if (rsel != 2'h3 && i_araddr[7:6] == REGION_CH) begin
			case (i_araddr[3:0])
				OFS_CFG: rd_word = {27'h0, filt_shift[rsel], therm[rsel]};
				OFS_LIM_A: rd_word = {16'h0, err_hi[rsel]};
				OFS_LIM_B: rd_word = {16'h0, err_lo[rsel]};
				default: rd_word = {16'h0, dflt[rsel]};
			endcase
		end else if (rsel != 2'h3 && i_araddr[7:6] == REGION_SLOT) begin
			case (i_araddr[3:0])
				OFS_CFG: rd_word = {28'h0, min_en[rsel], max_en[rsel],
					src[rsel]};
				OFS_LIM_A: rd_word = {16'h0, lim_max[rsel]};
				OFS_LIM_B: rd_word = {16'h0, lim_min[rsel]};
				default: rd_word = {16'h0, item_val[rsel]};
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= addr_ok(i_araddr) ? rd_word : 32'h0;
			o_rresp <= addr_ok(i_araddr) ? RESP_OKAY : RESP_DECERR;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input conditioning
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			in_err <= 3'h0;
			for (int c = 0; c < NUM_CH; c++)
				filt[c] <= 16'h0;
		end else if (i_sample_valid) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (i_sample_chan == 2'(c)) begin
					filt[c] <= filter_step(filt[c], i_sample_mv,
						filt_shift[c]);
					in_err[c] <= (i_sample_mv > err_hi[c]) ||
						(i_sample_mv < err_lo[c]);
				end
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			for (int c = 0; c < NUM_CH; c++) begin
				chan_val[c] <= 16'h0;
				item_val[c] <= 16'h0;
			end
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				chan_val[c] <= in_err[c] ? dflt[c] :
					linearise(filt[c], lin[c]);
				case (src[c])
					2'h0: item_val[c] <= chan_val[0];
					2'h1: item_val[c] <= chan_val[1];
					2'h2: item_val[c] <= chan_val[2];
					default: item_val[c] <= 16'h0;
				endcase
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			o_pullup_en <= 3'h0;
		else
			o_pullup_en <= therm;
	end

	////////////////////////////////////////////////////////////////////////
	// Alarm detection
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			alarm <= 3'h0;
		end else begin
			for (int m = 0; m < NUM_CH; m++)
				alarm[m] <= (i_engine_rpm >= rpm_limit) &&
					src[m] != SRC_NONE &&
					((max_en[m] && item_val[m] > lim_max[m]) ||
					(min_en[m] && item_val[m] < lim_min[m]));
		end
	end

	// Millisecond tick
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			tick_cnt <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= tick_cnt == TW'(TICK_CYCLES - 1);
			if (tick_cnt == TW'(TICK_CYCLES - 1))
				tick_cnt <= '0;
			else
				tick_cnt <= tick_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Warning page sequencing
	assign trig = alarm & ~(shown_once & i_item_on_layout);
	assign page_req = |trig && i_layout != FIFTH_SCREEN_LAYOUT;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			page_state <= PG_IDLE;
			ms_left <= 16'h0;
		end else begin
			unique case (page_state)
				PG_IDLE: if (page_req) begin
					page_state <= PG_HOLD;
					ms_left <= hold_ms;
				end
				PG_HOLD: if (ms_tick) begin
					if (ms_left <= 16'h1) begin
						page_state <= PG_HOLDOFF;
						ms_left <= holdoff_ms;
					end else begin
						ms_left <= ms_left - 16'h1;
					end
				end
				PG_HOLDOFF: if (ms_tick) begin
					if (ms_left <= 16'h1)
						page_state <= PG_IDLE;
					else
						ms_left <= ms_left - 16'h1;
				end
				default: page_state <= PG_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst)
			shown_once <= 3'h0;
		else if (page_state == PG_IDLE && page_req)
			shown_once <= alarm & (shown_once | i_item_on_layout);
		else
			shown_once <= shown_once & alarm;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_warning_page <= 1'b0;
			o_item_red <= 3'h0;
			o_alarm_active <= 1'b0;
		end else begin
			o_warning_page <= page_state == PG_HOLD &&
				i_layout != FIFTH_SCREEN_LAYOUT;
			o_item_red <= alarm & i_item_on_layout &
				{3{i_layout != FIFTH_SCREEN_LAYOUT}};
			o_alarm_active <= |alarm;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts: set wins over write-one-to-clear
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			int_stat <= 6'h00;
			alarm_q <= 3'h0;
			err_q <= 3'h0;
			o_irq <= 1'b0;
		end else begin
			alarm_q <= alarm;
			err_q <= in_err;
			int_stat <= (int_stat & ~((do_wr && ws_q[0] &&
				aw_q == {REGION_GLOBAL, OFS_INT_STAT}) ? wd_q[5:0] : 6'h00))
				| {in_err & ~err_q, alarm & ~alarm_q};
			o_irq <= |(int_stat & int_mask);
		end
	end
endmodule
`default_nettype wire

// file: smon_sensor_model.sv
`timescale 1ns/10ps
`default_nettype none
// Sensor front end: one sample per request, idle line scrambled
module smon_sensor_model (
	input wire logic i_clock,
	input wire logic i_go,
	input wire logic [1:0] i_ch,
	input wire logic [15:0] i_mv,
	output logic o_sample_valid,
	output logic [1:0] o_sample_chan,
	output logic [15:0] o_sample_mv
);
	initial begin
		o_sample_valid = 1'h0;
		o_sample_chan = 2'h0;
		o_sample_mv = 16'h0;
	end
	always @(posedge i_clock) begin
		o_sample_valid <= i_go;
		o_sample_chan <= i_ch;
		o_sample_mv <= i_go ? i_mv : ~o_sample_mv;
	end
endmodule
`default_nettype wire

// file: smon_sva.sv
`timescale 1ns/10ps
`default_nettype none
module smon_sva
	import smon_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [3:0] i_layout,
	input wire logic o_warning_page,
	input wire logic [2:0] o_item_red,
	input wire logic o_alarm_active,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////
	property p_wr_lat;
		!o_bvalid && i_awvalid && o_awready && i_wvalid && o_wready
			|-> ##2 o_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_rd_lat;
		i_arvalid && o_arready |=> o_rvalid && !o_arready;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_b_hold;
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_decerr;
		o_rvalid && o_rresp == RESP_DECERR |-> o_rdata == 32'h0;
	endproperty
	a_decerr: assert property (p_decerr) else $error("refused read data");
	property p_page_hold;
		$rose(o_warning_page) |-> o_warning_page [*6];
	endproperty
	a_page_hold: assert property (p_page_hold) else $error("page short");
	property p_page_off;
		$fell(o_warning_page) |-> !o_warning_page [*8];
	endproperty
	a_page_off: assert property (p_page_off) else $error("page early");
	property p_l5;
		$past(i_layout) == FIFTH_SCREEN_LAYOUT
			&& $past(i_layout, 2) == FIFTH_SCREEN_LAYOUT
			|-> !o_warning_page && o_item_red == 3'h0;
	endproperty
	a_l5: assert property (p_l5) else $error("warning on fifth layout");
	property p_red;
		|o_item_red |-> o_alarm_active;
	endproperty
	a_red: assert property (p_red) else $error("red without alarm");
	c_page: cover property (o_warning_page);
	c_irq: cover property (o_irq);
	c_red: cover property (|o_item_red);
endmodule
bind smon_top smon_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);
`default_nettype wire

// file: smon_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) chk(32'(a), 32'(e))
module smon_tb_top;
	import smon_pkg::*;
	logic i_clock = 1'h0, i_sys_rst = 1'h1, go = 1'h0;
	logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
	logic i_arvalid = 1'h0, i_rready = 1'h0;
	logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata, d;
	logic [3:0] i_wstrb = 4'hF, i_layout = 4'h0;
	logic [2:0] i_item_on_layout = 3'h0, o_pullup_en, o_item_red;
	logic [15:0] i_engine_rpm = 16'h03E8, mv = 16'h0, i_sample_mv, v, y;
	logic [1:0] ch = 2'h0, i_sample_chan, o_bresp, o_rresp, r;
	logic i_sample_valid, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic o_warning_page, o_alarm_active, o_irq;
	// Timers first: the window write below raises an alarm at once
	logic [7:0] ca[9] = '{8'h00, 8'h04, 8'h08, 8'h44, 8'h48, 8'h4C, 8'h80,
		8'h84, 8'h88};
	logic [15:0] cd[9] = '{16'h01F4, 16'h0002, 16'h0003, 16'h0FA0, 16'h0064,
		16'h0777, 16'h000C, 16'h0BB8, 16'h03E8};
	logic [15:0] cv[4] = '{16'h0FA1, 16'h0FA0, 16'h0064, 16'h0063};
	int mismatches = 0, comparisons = 0, cyc = 0, n;
	smon_top #(.TICK_CYCLES(8)) DUT (.*);
	smon_sensor_model SEN (.i_clock, .i_go(go), .i_ch(ch), .i_mv(mv),
		.o_sample_valid(i_sample_valid), .o_sample_chan(i_sample_chan),
		.o_sample_mv(i_sample_mv));
	always #4 i_clock = ~i_clock;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] a, e);
		comparisons++;
		if (a !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] w);
		i_awaddr <= a;
		i_wdata <= w;
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		do begin
			@(posedge i_clock);
			if (o_awready) i_awvalid <= 1'h0;
			if (o_wready) i_wvalid <= 1'h0;
		end while (!o_bvalid);
		r = o_bresp;
		i_bready <= 1'h0;
		@(posedge i_clock);
	endtask
	task automatic rd(input logic [7:0] a);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		do begin
			@(posedge i_clock);
			if (o_arready) i_arvalid <= 1'h0;
		end while (!o_rvalid);
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'h0;
		@(posedge i_clock);
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		rd(a);
		`CHK(d[15:0], e);
	endtask
	task automatic smp(input logic [1:0] c, input logic [15:0] x);
		go <= 1'h1;
		ch <= c;
		mv <= x;
		@(posedge i_clock);
		go <= 1'h0;
		repeat (8) @(posedge i_clock);
	endtask
	function automatic logic [15:0] item(input logic [15:0] x);
		return (x > 16'h0FA0 || x < 16'h0064) ? 16'h0777 : x;
	endfunction
	function automatic logic [15:0] filt(input logic [15:0] a, x, int k);
		return 16'(int'(a) + ((int'(x) - int'(a)) >>> k));
	endfunction
	////////////////////////////////////////
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'hFF094DAF));
		repeat (2) @(posedge i_clock);
		i_sys_rst <= 1'h0;
		@(posedge i_clock);
		rc(8'h04, HOLD_MS_RST);
		rc(8'h08, HOLDOFF_MS_RST);
		rd(8'h3C);
		`CHK(r, RESP_DECERR);
		wr(8'h3C, 32'h1);
		`CHK(r, RESP_DECERR);
		wr(8'h40, 32'h1);
		`CHK(o_pullup_en, 3'h1);
		foreach (ca[i]) wr(ca[i], {16'h0, cd[i]});
		$display("test registers done");
		repeat (8) begin
			v = 16'($urandom_range(5000));
			smp(2'h0, v);
			rc(8'h8C, item(v));
		end
		// Flatten segment 4..5 of channel 0, then restore it
		wr(8'h70, 32'h00040A00);
		`CHK(r, RESP_OKAY);
		smp(2'h0, 16'h0900);
		rc(8'h8C, 16'h0A00);
		wr(8'h70, 32'h00040800);
		foreach (cv[i]) begin
			smp(2'h0, cv[i]);
			rc(8'h8C, item(cv[i]));
		end
		rd(8'h0C);
		`CHK(d[0], 1'h1);
		smp(2'h3, 16'h09C4);
		rc(8'h8C, 16'h0777);
		smp(2'h0, 16'h07D0);
		wr(8'h40, 32'h3);
		y = 16'h07D0;
		repeat (3) begin
			y = filt(y, 16'h0960, 1);
			smp(2'h0, 16'h0960);
			rc(8'h8C, y);
		end
		wr(8'h40, 32'h1);
		$display("test conditioning done");
		smp(2'h0, 16'h07D0);
		repeat (60) @(posedge i_clock);
		smp(2'h0, 16'h0DAC);
		`CHK(o_alarm_active, 1'h1);
		`CHK(o_warning_page, 1'h1);
		`CHK(o_irq, 1'h0);
		wr(8'h14, 32'h1);
		`CHK(o_irq, 1'h1);
		wr(8'h10, 32'h1);
		`CHK(o_irq, 1'h0);
		smp(2'h0, 16'h01F4);
		`CHK(o_alarm_active, 1'h1);
		i_engine_rpm <= 16'h0064;
		smp(2'h0, 16'h01F4);
		`CHK(o_alarm_active, 1'h0);
		i_engine_rpm <= 16'h03E8;
		$display("test alarms done");
		smp(2'h0, 16'h07D0);
		repeat (60) @(posedge i_clock);
		i_item_on_layout <= 3'h1;
		smp(2'h0, 16'h0DAC);
		`CHK(o_item_red, 3'h1);
		repeat (20) @(posedge i_clock);
		n = 0;
		repeat (60) begin
			@(posedge i_clock);
			if (o_warning_page !== 1'h0) n++;
		end
		`CHK(n, 0);
		i_layout <= FIFTH_SCREEN_LAYOUT;
		smp(2'h0, 16'h07D0);
		repeat (60) @(posedge i_clock);
		smp(2'h0, 16'h0DAC);
		`CHK(o_alarm_active, 1'h1);
		`CHK(o_warning_page, 1'h0);
		`CHK(o_item_red, 3'h0);
		$display("test layouts done");
		report_and_stop();
	end
endmodule
`default_nettype wire
